//--- pst_pkg.sv
// pst_pkg.sv - shared constants, register map and state encodings
// assumes both ends and the bench compile this first
`default_nettype none
package pst_pkg;
  localparam int CLK_NS = 5;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
  localparam logic [6:0] DEV_ADDR = 7'h13;
  localparam logic [7:0] REG_CMD = 8'h80;
  localparam logic [7:0] REG_RATE = 8'h82;
  localparam logic [7:0] REG_CUR = 8'h83;
  localparam logic [7:0] REG_ALS = 8'h84;
  localparam logic [7:0] REG_ICTL = 8'h89;
  localparam logic [7:0] REG_LTH = 8'h8A;
  localparam logic [7:0] REG_LTL = 8'h8B;
  localparam logic [7:0] REG_UTH = 8'h8C;
  localparam logic [7:0] REG_UTL = 8'h8D;
  localparam logic [7:0] REG_FLAGS = 8'h8E;
  localparam logic [7:0] REG_MODT = 8'h8F;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_MODT = 8'h01;
  localparam int MODT_DLY_LSB = 5;
  localparam int MODT_FRQ_LSB = 3;
  localparam int MODT_DEAD_LSB = 0;
  localparam logic [1:0] FRQ_390K = 2'h0;
  localparam logic [1:0] FRQ_781K = 2'h1;
  localparam logic [1:0] FRQ_1M56 = 2'h2;
  localparam logic [1:0] FRQ_3M12 = 2'h3;
  localparam int CMD_SELFT_BIT = 0;
  localparam int CMD_PROX_BIT = 1;
  localparam int ICTL_CNT_LSB = 5;
  localparam int ICTL_PRDY_BIT = 3;
  localparam int ICTL_ARDY_BIT = 2;
  localparam int ICTL_EN_BIT = 1;
  localparam int ICTL_SEL_BIT = 0;
  localparam int FLG_HI = 0;
  localparam int FLG_LO = 1;
  localparam int FLG_ARDY = 2;
  localparam int FLG_PRDY = 3;
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_STAT = 8'h04;
  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_ADDR = 3'b001,
    SL_PTR = 3'b010,
    SL_DATA = 3'b011,
    SL_ACK = 3'b100,
    SL_TX = 3'b101,
    SL_TXACK = 3'b110
  } pst_sl_type;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BYTE = 2'b10,
    HS_STOP = 2'b11
  } pst_hs_type;
endpackage : pst_pkg
`default_nettype wire

//--- pst_link_if.sv
// pst_link_if.sv - two-wire link plus interrupt line between the ends
// assumes pull-ups: a line reads high unless an enabled driver pulls it low
`default_nettype none
interface pst_link_if;
  logic scl;
  logic sda;
  logic int_n;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_int_o;
  logic dev_int_oe;
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  assign int_n = ~(dev_int_oe & ~dev_int_o);
  modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe, output dev_int_o, output dev_int_oe);
  modport host(input scl, input sda, input int_n, output host_scl_o, output host_scl_oe,
               output host_sda_o, output host_sda_oe);
endinterface : pst_link_if
`default_nettype wire

//--- pst_dev.sv
// pst_dev.sv - sensor end: two-wire slave, register set, threshold interrupt
// assumes the front end gives one-cycle done strobes on ref_clk with results
// Operation
// - 3-bit modulation delay, 0 to 7, reset 0
// - carrier select defaults to 390 kHz code
// - dead-time window blanks received signal edges
// - 3-bit dead time field, reset 1
// - host avoids dead time value zero
// - threshold interrupt only after consecutive out-of-band hits
// - emitter current register at 83h
// - proximity rate register at 82h
// - ambient light config register at 84h
// - interrupt control at 89h: count, enable, source
// - source bit 0 compares proximity results
// - lower threshold bytes at 8Ah, 8Bh
// - upper threshold bytes at 8Ch, 8Dh
// - command 80h starts self-timed proximity
// - host reads status at 8Eh
// - below lower threshold sets low flag
// - host writes 26h, register, one data byte
// - flags sticky, cleared by writing one
// - interrupt pin low while any flag set
// - flag bits: high, low, ambient, proximity
//
// Register access over Wishbone was decided locally.
`default_nettype none
module pst_dev #(
  parameter logic [6:0] DEV_ADDR = pst_pkg::DEV_ADDR
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  pst_link_if.dev link,
  input wire logic [15:0] prox_data,
  input wire logic prox_done,
  input wire logic [15:0] als_data,
  input wire logic als_done,
  output logic prox_on,
  output logic selftimed_on,
  output logic [2:0] prox_rate,
  output logic [5:0] emitter_drive_level,
  output logic [7:0] als_cfg,
  output logic [2:0] mod_delay,
  output logic [1:0] carrier_sel,
  output logic [2:0] dead_time
);
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    pst_pkg::pst_sl_type st;
    pst_pkg::pst_sl_type after;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic drv_lo;
    logic sda_oe;
    logic int_oe;
    logic [7:0] cmd;
    logic [7:0] rate;
    logic [7:0] cur;
    logic [7:0] als;
    logic [7:0] ictl;
    logic [7:0] lth;
    logic [7:0] ltl;
    logic [7:0] uth;
    logic [7:0] utl;
    logic [7:0] modt;
    logic [3:0] flags;
    logic [7:0] hits;
  } pst_dev_type;

  localparam pst_dev_type RST = '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
                                  st: pst_pkg::SL_IDLE, after: pst_pkg::SL_IDLE,
                                  cmd: pst_pkg::RST_REG, modt: pst_pkg::RST_MODT, default: '0};

  pst_dev_type r_r;
  pst_dev_type r_nxt;
  logic scl_v;
  logic sda_v;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic src_done;
  logic above;
  logic below;
  logic [15:0] src_val;
  logic [7:0] need;
  logic [7:0] rdv;

  function automatic logic [7:0] rd_reg(input pst_dev_type s, input logic [7:0] a);
    rd_reg = 8'h00;
    if (a == pst_pkg::REG_CMD) begin
      rd_reg = s.cmd;
    end else if (a == pst_pkg::REG_RATE) begin
      rd_reg = s.rate;
    end else if (a == pst_pkg::REG_CUR) begin
      rd_reg = s.cur;
    end else if (a == pst_pkg::REG_ALS) begin
      rd_reg = s.als;
    end else if (a == pst_pkg::REG_ICTL) begin
      rd_reg = s.ictl;
    end else if (a == pst_pkg::REG_LTH) begin
      rd_reg = s.lth;
    end else if (a == pst_pkg::REG_LTL) begin
      rd_reg = s.ltl;
    end else if (a == pst_pkg::REG_UTH) begin
      rd_reg = s.uth;
    end else if (a == pst_pkg::REG_UTL) begin
      rd_reg = s.utl;
    end else if (a == pst_pkg::REG_FLAGS) begin
      rd_reg = {4'h0, s.flags};
    end else if (a == pst_pkg::REG_MODT) begin
      rd_reg = s.modt;
    end
  endfunction : rd_reg

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_nxt = r_r;
    rdv = rd_reg(r_r, r_r.ptr);
    r_nxt.scl_s = {r_r.scl_s[1:0], link.scl};
    r_nxt.sda_s = {r_r.sda_s[1:0], link.sda};
    // a change counts only once stages two and three agree
    scl_v = (r_r.scl_s[1] == r_r.scl_s[2]) ? r_r.scl_s[2] : r_r.scl_f;
    sda_v = (r_r.sda_s[1] == r_r.sda_s[2]) ? r_r.sda_s[2] : r_r.sda_f;
    r_nxt.scl_f = scl_v;
    r_nxt.sda_f = sda_v;
    rise = scl_v & ~r_r.scl_f;
    fall = ~scl_v & r_r.scl_f;
    start = scl_v & r_r.scl_f & r_r.sda_f & ~sda_v;
    stop = scl_v & r_r.scl_f & ~r_r.sda_f & sda_v;
    if (start) begin
      r_nxt.st = pst_pkg::SL_ADDR;
      r_nxt.bitcnt = 4'h0;
      r_nxt.sda_oe = 1'b0;
    end else if (stop) begin
      r_nxt.st = pst_pkg::SL_IDLE;
      r_nxt.sda_oe = 1'b0;
    end else begin
      case (r_r.st)
        pst_pkg::SL_ADDR, pst_pkg::SL_PTR, pst_pkg::SL_DATA: begin
          if (rise) begin
            r_nxt.sh = {r_r.sh[6:0], sda_v};
            r_nxt.bitcnt = r_r.bitcnt + 4'h1;
          end else if (fall && r_r.bitcnt == 4'h8) begin
            r_nxt.st = pst_pkg::SL_ACK;
            r_nxt.sda_oe = 1'b1;
            r_nxt.after = pst_pkg::SL_DATA;
            if (r_r.st == pst_pkg::SL_ADDR) begin
              r_nxt.after = r_r.sh[0] ? pst_pkg::SL_TX : pst_pkg::SL_PTR;
              // foreign address: stay off the bus until the next start
              if (r_r.sh[7:1] != DEV_ADDR) begin
                r_nxt.st = pst_pkg::SL_IDLE;
                r_nxt.sda_oe = 1'b0;
              end
            end else if (r_r.st == pst_pkg::SL_PTR) begin
              r_nxt.ptr = r_r.sh;
            end else begin
              r_nxt.ptr = r_r.ptr + 8'h01;
              if (r_r.ptr == pst_pkg::REG_CMD) begin
                r_nxt.cmd = r_r.sh;
              end else if (r_r.ptr == pst_pkg::REG_RATE) begin
                r_nxt.rate = r_r.sh;
              end else if (r_r.ptr == pst_pkg::REG_CUR) begin
                r_nxt.cur = r_r.sh;
              end else if (r_r.ptr == pst_pkg::REG_ALS) begin
                r_nxt.als = r_r.sh;
              end else if (r_r.ptr == pst_pkg::REG_ICTL) begin
                r_nxt.ictl = r_r.sh;
              end else if (r_r.ptr == pst_pkg::REG_LTH) begin
                r_nxt.lth = r_r.sh;
              end else if (r_r.ptr == pst_pkg::REG_LTL) begin
                r_nxt.ltl = r_r.sh;
              end else if (r_r.ptr == pst_pkg::REG_UTH) begin
                r_nxt.uth = r_r.sh;
              end else if (r_r.ptr == pst_pkg::REG_UTL) begin
                r_nxt.utl = r_r.sh;
              end else if (r_r.ptr == pst_pkg::REG_FLAGS) begin
                r_nxt.flags = r_r.flags & ~r_r.sh[3:0];
              end else if (r_r.ptr == pst_pkg::REG_MODT) begin
                r_nxt.modt = r_r.sh;
              end
            end
          end
        end
        pst_pkg::SL_ACK: begin
          if (fall) begin
            r_nxt.st = r_r.after;
            r_nxt.bitcnt = 4'h0;
            r_nxt.sda_oe = 1'b0;
            if (r_r.after == pst_pkg::SL_TX) begin
              r_nxt.sh = rdv;
              r_nxt.sda_oe = ~rdv[7];
            end
          end
        end
        pst_pkg::SL_TX: begin
          if (rise) begin
            r_nxt.bitcnt = r_r.bitcnt + 4'h1;
          end else if (fall && r_r.bitcnt == 4'h8) begin
            r_nxt.sda_oe = 1'b0;
            r_nxt.st = pst_pkg::SL_TXACK;
          end else if (fall) begin
            r_nxt.sh = {r_r.sh[6:0], 1'b0};
            r_nxt.sda_oe = ~r_r.sh[6];
          end
        end
        pst_pkg::SL_TXACK: begin
          if (rise && sda_v) begin
            r_nxt.st = pst_pkg::SL_IDLE;
          end else if (rise) begin
            r_nxt.ptr = r_r.ptr + 8'h01;
            r_nxt.st = pst_pkg::SL_ACK;
            r_nxt.after = pst_pkg::SL_TX;
          end
        end
        default: begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // events come after the clear so a set in the same cycle wins
    src_val = r_r.ictl[pst_pkg::ICTL_SEL_BIT] ? als_data : prox_data;
    src_done = r_r.ictl[pst_pkg::ICTL_SEL_BIT] ? als_done : prox_done;
    above = src_val >= {r_r.uth, r_r.utl};
    below = src_val < {r_r.lth, r_r.ltl};
    need = 8'h01 << r_r.ictl[pst_pkg::ICTL_CNT_LSB +: 3];
    if (src_done && r_r.ictl[pst_pkg::ICTL_EN_BIT]) begin
      if (above || below) begin
        if ({1'b0, r_r.hits} + 9'h001 >= {1'b0, need}) begin
          r_nxt.hits = 8'h00;
          if (above) begin
            r_nxt.flags[pst_pkg::FLG_HI] = 1'b1;
          end
          if (below) begin
            r_nxt.flags[pst_pkg::FLG_LO] = 1'b1;
          end
        end else begin
          r_nxt.hits = r_r.hits + 8'h01;
        end
      end else begin
        r_nxt.hits = 8'h00;
      end
    end
    if (prox_done && r_r.ictl[pst_pkg::ICTL_PRDY_BIT]) begin
      r_nxt.flags[pst_pkg::FLG_PRDY] = 1'b1;
    end
    if (als_done && r_r.ictl[pst_pkg::ICTL_ARDY_BIT]) begin
      r_nxt.flags[pst_pkg::FLG_ARDY] = 1'b1;
    end
    r_nxt.int_oe = |r_nxt.flags;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r_r <= RST;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.dev_sda_o = r_r.drv_lo;
  assign link.dev_sda_oe = r_r.sda_oe;
  assign link.dev_int_o = r_r.drv_lo;
  assign link.dev_int_oe = r_r.int_oe;
  assign prox_on = r_r.cmd[pst_pkg::CMD_PROX_BIT];
  assign selftimed_on = r_r.cmd[pst_pkg::CMD_SELFT_BIT];
  assign prox_rate = r_r.rate[2:0];
  assign emitter_drive_level = r_r.cur[5:0];
  assign als_cfg = r_r.als;
  assign mod_delay = r_r.modt[pst_pkg::MODT_DLY_LSB +: 3];
  // codes follow FRQ_390K..FRQ_3M12; only the lower two suit the emitter
  assign carrier_sel = r_r.modt[pst_pkg::MODT_FRQ_LSB +: 2];
  assign dead_time = r_r.modt[pst_pkg::MODT_DEAD_LSB +: 3];
endmodule : pst_dev
`default_nettype wire

//--- pst_host.sv
// pst_host.sv - controller end: wishbone registers drive two-wire transfers
// assumes one single-byte write or read per order; no clock stretching
`default_nettype none
module pst_host #(
  parameter int QTR_CYC = pst_pkg::QTR_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  pst_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq
);
  typedef struct packed {
    logic [2:0] sda_s;
    logic [2:0] int_s;
    logic sda_f;
    logic irq_f;
    logic ack;
    logic [31:0] dat;
    logic [7:0] ra;
    logic [7:0] wd;
    logic rd;
    logic busy;
    logic nack;
    logic [7:0] rdat;
    pst_pkg::pst_hs_type st;
    logic [2:0] item;
    logic [1:0] q;
    logic [15:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic drv_lo;
    logic scl_oe;
    logic sda_oe;
  } pst_host_type;

  localparam pst_host_type RST = '{sda_s: 3'h7, int_s: 3'h7, sda_f: 1'b1, st: pst_pkg::HS_IDLE, default: '0};

  pst_host_type r_r;
  pst_host_type r_nxt;
  logic sda_v;
  logic req;
  logic tick;
  logic fin;
  logic rx;

  // transfer plan: write is S,B,B,B,P; read is S,B,B,S,B,B,P
  function automatic pst_pkg::pst_hs_type kind_of(input logic rd, input logic [2:0] it);
    kind_of = pst_pkg::HS_BYTE;
    if (it == 3'h0 || (rd && it == 3'h3)) begin
      kind_of = pst_pkg::HS_START;
    end else if ((!rd && it == 3'h4) || it == 3'h6) begin
      kind_of = pst_pkg::HS_STOP;
    end
  endfunction : kind_of

  function automatic logic [7:0] byte_of(input logic rd, input logic [2:0] it, input logic [7:0] ra,
                                         input logic [7:0] wd);
    byte_of = 8'hFF;
    if (it == 3'h1) begin
      byte_of = {pst_pkg::DEV_ADDR, 1'b0};
    end else if (it == 3'h2) begin
      byte_of = ra;
    end else if (it == 3'h3 && !rd) begin
      byte_of = wd;
    end else if (it == 3'h4 && rd) begin
      byte_of = {pst_pkg::DEV_ADDR, 1'b1};
    end
  endfunction : byte_of

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_nxt = r_r;
    fin = 1'b0;
    r_nxt.sda_s = {r_r.sda_s[1:0], link.sda};
    r_nxt.int_s = {r_r.int_s[1:0], link.int_n};
    sda_v = (r_r.sda_s[1] == r_r.sda_s[2]) ? r_r.sda_s[2] : r_r.sda_f;
    r_nxt.sda_f = sda_v;
    if (r_r.int_s[1] == r_r.int_s[2]) begin
      r_nxt.irq_f = ~r_r.int_s[2];
    end
    rx = r_r.rd && r_r.item == 3'h5;
    req = wb_cyc_i & wb_stb_i;
    r_nxt.ack = req & ~r_r.ack;
    if (req && !r_r.ack) begin
      r_nxt.dat = 32'h0000_0000;
      if (wb_adr_i == pst_pkg::HREG_CTRL) begin
        r_nxt.dat = {7'h00, r_r.busy, 7'h00, r_r.rd, r_r.wd, r_r.ra};
      end else if (wb_adr_i == pst_pkg::HREG_STAT) begin
        r_nxt.dat = {16'h0000, r_r.rdat, 5'h00, r_r.irq_f, r_r.nack, r_r.busy};
      end
    end
    // writes land on the edge where the master sees ack
    if (req && r_r.ack && wb_we_i && wb_adr_i == pst_pkg::HREG_CTRL && !r_r.busy) begin
      if (wb_sel_i[0]) begin
        r_nxt.ra = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        r_nxt.wd = wb_dat_i[15:8];
      end
      if (wb_sel_i[2]) begin
        r_nxt.rd = wb_dat_i[16];
      end
      if (wb_sel_i[3] && wb_dat_i[24]) begin
        r_nxt.busy = 1'b1;
        r_nxt.nack = 1'b0;
        r_nxt.st = pst_pkg::HS_START;
        r_nxt.item = 3'h0;
        r_nxt.q = 2'h0;
        r_nxt.div = 16'h0000;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    tick = r_r.div == 16'(QTR_CYC - 1);
    if (r_r.st != pst_pkg::HS_IDLE) begin
      r_nxt.div = tick ? 16'h0000 : r_r.div + 16'h0001;
    end
    if (r_r.st != pst_pkg::HS_IDLE && tick) begin
      r_nxt.q = r_r.q + 2'h1;
      case (r_r.st)
        pst_pkg::HS_START: begin
          case (r_r.q)
            2'h0: r_nxt.sda_oe = 1'b0;
            2'h1: r_nxt.scl_oe = 1'b0;
            2'h2: r_nxt.sda_oe = 1'b1;
            default: begin
              r_nxt.scl_oe = 1'b1;
              fin = 1'b1;
            end
          endcase
        end
        pst_pkg::HS_BYTE: begin
          case (r_r.q)
            2'h0: r_nxt.sda_oe = (r_r.bitn < 4'h8) & ~r_r.sh[7];
            2'h1: r_nxt.scl_oe = 1'b0;
            2'h2: begin
              if (r_r.bitn < 4'h8 && rx) begin
                r_nxt.rdat = {r_r.rdat[6:0], sda_v};
              end else if (r_r.bitn == 4'h8 && !rx && sda_v) begin
                r_nxt.nack = 1'b1;
              end
            end
            default: begin
              r_nxt.scl_oe = 1'b1;
              r_nxt.sh = {r_r.sh[6:0], 1'b0};
              r_nxt.bitn = r_r.bitn + 4'h1;
              fin = r_r.bitn == 4'h8;
            end
          endcase
        end
        default: begin
          case (r_r.q)
            2'h0: r_nxt.sda_oe = 1'b1;
            2'h1: r_nxt.scl_oe = 1'b0;
            2'h2: r_nxt.sda_oe = 1'b0;
            default: begin
              r_nxt.st = pst_pkg::HS_IDLE;
              r_nxt.busy = 1'b0;
            end
          endcase
        end
      endcase
    end
    // a refused byte skips the rest of the plan and closes with a stop
    if (fin) begin
      r_nxt.item = r_r.item + 3'h1;
      r_nxt.bitn = 4'h0;
      r_nxt.sh = byte_of(r_r.rd, r_r.item + 3'h1, r_r.ra, r_r.wd);
      r_nxt.st = r_nxt.nack ? pst_pkg::HS_STOP : kind_of(r_r.rd, r_r.item + 3'h1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r_r <= RST;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  assign link.host_scl_o = r_r.drv_lo;
  assign link.host_scl_oe = r_r.scl_oe;
  assign link.host_sda_o = r_r.drv_lo;
  assign link.host_sda_oe = r_r.sda_oe;
  assign wb_dat_o = r_r.dat;
  assign wb_ack_o = r_r.ack;
  assign irq = r_r.irq_f;
endmodule : pst_host
`default_nettype wire

//--- pst_link_assertions.sv
// pst_link_assertions.sv - wire checks on the two-wire link and the interrupt line
// assumes the interface signals of one host end and one device end, quarter count from the bench
`default_nettype none
module pst_link_checker #(
  parameter int QTR_CYC = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic int_n,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_int_o,
  input wire logic dev_int_oe
);
  logic [15:0] hi_cnt_r;
  logic [15:0] lo_cnt_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // run lengths of the host pull on scl; saturate so idle gaps cannot wrap
  always_ff @(posedge ref_clk) begin
    if (!nrst || !host_scl_oe) hi_cnt_r <= 16'h0;
    else if (hi_cnt_r != 16'hFFFF) hi_cnt_r <= hi_cnt_r + 16'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (!nrst || host_scl_oe) lo_cnt_r <= 16'h0;
    else if (lo_cnt_r != 16'hFFFF) lo_cnt_r <= lo_cnt_r + 16'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_INT_OD: assert property (dev_int_oe |-> !dev_int_o) else $error("int line driven high");
  AST_DSDA_OD: assert property (dev_sda_oe |-> !dev_sda_o) else $error("device sda driven high");
  AST_HSDA_OD: assert property (host_sda_oe |-> !host_sda_o) else $error("host sda driven high");
  AST_HSCL_OD: assert property (host_scl_oe |-> !host_scl_o) else $error("host scl driven high");
  // a flag clears only on a data byte, so the pin can rise only a few cycles into a low scl phase
  AST_INT_RISE: assert property ($rose(int_n) |-> !scl && !$past(scl, 3)) else $error("int rose off a byte");
  AST_INT_STAY: assert property (!int_n && scl |=> !int_n) else $error("int released with scl high");
  AST_DEV_HOLD: assert property (scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("device sda moved");
  AST_DEV_RISE: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl, 2)) else $error("device drove early");
  AST_SCL_LO: assert property ($fell(host_scl_oe) |-> hi_cnt_r == 16'(2 * QTR_CYC)) else $error("scl low time");
  AST_SCL_HI: assert property ($rose(host_scl_oe) |-> lo_cnt_r == 16'(2 * QTR_CYC) ||
    lo_cnt_r >= 16'(3 * QTR_CYC)) else $error("scl high time");
endmodule : pst_link_checker
`default_nettype wire

//--- tb.sv
// tb.sv - self-checking bench: wishbone orders to the host end, link to the device end
// assumes pst_pkg, pst_link_if and both ends compiled first; the front end is modelled by strobes
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int QTR = 8;
  localparam logic [7:0] SREG [9] = '{pst_pkg::REG_CUR, pst_pkg::REG_RATE, pst_pkg::REG_ALS, pst_pkg::REG_ICTL,
    pst_pkg::REG_LTH, pst_pkg::REG_LTL, pst_pkg::REG_UTH, pst_pkg::REG_UTL, pst_pkg::REG_CMD};
  localparam logic [7:0] SVAL [9] = '{8'h14, 8'h01, 8'h1D, 8'h22, 8'h00, 8'h00, 8'h16, 8'hE4, 8'h03};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, prox_done = 1'b0, als_done = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [15:0] prox_data = 16'h0, als_data = 16'h0;
  logic wb_ack_o, irq, prox_on, selftimed_on;
  logic [31:0] wb_dat_o, q;
  logic [2:0] prox_rate, mod_delay, dead_time;
  logic [5:0] emitter_drive_level;
  logic [1:0] carrier_sel;
  logic [7:0] als_cfg, ab, r;
  logic [63:0] m;
  logic [63:0] q_exp[$];
  logic [7:0] a_q[$];
  int n_fail = 0, n_tests = 0, seed = 32'h4097, cyc_n = 0, i, j;
  always #2.5 ref_clk = ~ref_clk;
  pst_link_if link();
  pst_dev i_pst_dev(.ref_clk, .nrst, .ce(1'b1), .link(link), .prox_data, .prox_done, .als_data, .als_done,
    .prox_on, .selftimed_on, .prox_rate, .emitter_drive_level, .als_cfg, .mod_delay, .carrier_sel, .dead_time);
  pst_host #(.QTR_CYC(QTR)) i_pst_host(.ref_clk, .nrst, .ce(1'b1), .link(link), .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .irq);
  pst_link_checker #(.QTR_CYC(QTR)) i_pst_link_checker(.ref_clk, .nrst, .scl(link.scl), .int_n(link.int_n),
    .host_scl_o(link.host_scl_o), .host_scl_oe(link.host_scl_oe), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .dev_int_o(link.dev_int_o), .dev_int_oe(link.dev_int_oe));
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle; read expectations queue up for the monitor, mask 0 skips
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] mk, input logic [31:0] e);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    if (!w) q_exp.push_back({mk, e});
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  // one link transfer; polls busy under a bound, then checks done, no nack and read byte
  task dev(input logic rd, input logic [7:0] ra, input logic [7:0] wd, input logic [7:0] e, input logic [7:0] mk);
    int k;
    a_q.push_back(8'h26);
    if (rd) a_q.push_back(8'h27);
    wb(1'b1, pst_pkg::HREG_CTRL, {7'h0, 1'b1, 7'h0, rd, wd, ra}, 32'h0, 32'h0);
    k = 0;
    do begin
      wb(1'b0, pst_pkg::HREG_STAT, 32'h0, 32'h0, 32'h0);
      k++;
    end while (q[0] !== 1'b0 && k < 4000);
    wb(1'b0, pst_pkg::HREG_STAT, 32'h0, {16'h0, mk, 8'h03}, {16'h0, e, 8'h00});
  endtask : dev
  task hit(input logic [15:0] d);
    prox_data <= d;
    prox_done <= 1'b1;
    @(posedge ref_clk);
    prox_done <= 1'b0;
    als_done <= 1'b0;
    repeat (7) @(posedge ref_clk);
  endtask : hit
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && !wb_we_i && q_exp.size() > 0) begin
      m = q_exp.pop_front();
      if (m[63:32] != 32'h0) chk("wb_dat_o", m[31:0], wb_dat_o & m[63:32]);
    end
    cyc_n++;
    // longest legal run is well under this; a hang lands here
    if (cyc_n == 90000) begin
      n_fail++;
      close_out;
    end
  end
  // address byte after each start or repeated start, msb first on scl rise
  always @(negedge link.sda) if (link.scl === 1'b1) begin
    for (j = 0; j < 8; j++) begin
      @(posedge link.scl) ab = {ab[6:0], link.sda};
    end
    chk("addr_byte", a_q.pop_front(), ab);
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("mod_delay", 32'h0, mod_delay);
    chk("carrier_sel", pst_pkg::FRQ_390K, carrier_sel);
    chk("dead_time", 32'h1, dead_time);
    wb(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF, 32'h0);
    dev(1'b1, pst_pkg::REG_MODT, 8'h00, pst_pkg::RST_MODT, 8'hFF);
    // dead time never zero here; carrier walks all four codes
    for (i = 1; i < 8; i++) begin
      dev(1'b0, pst_pkg::REG_MODT, {i[2:0], i[1:0], i[2:0]}, 8'h00, 8'h00);
      chk("mod_delay", i[2:0], mod_delay);
      chk("carrier_sel", i[1:0], carrier_sel);
      chk("dead_time", i[2:0], dead_time);
    end
    dev(1'b0, pst_pkg::REG_MODT, pst_pkg::RST_MODT, 8'h00, 8'h00);
    for (i = 0; i < 9; i++) dev(1'b0, SREG[i], SVAL[i], 8'h00, 8'h00);
    chk("emitter_drive_level", 32'h14, emitter_drive_level);
    chk("prox_rate", 32'h1, prox_rate);
    chk("als_cfg", 32'h1D, als_cfg);
    chk("prox_on", 32'h1, prox_on);
    chk("selftimed_on", 32'h1, selftimed_on);
    dev(1'b1, pst_pkg::REG_ICTL, 8'h00, 8'h22, 8'hFF);
    dev(1'b1, pst_pkg::REG_UTL, 8'h00, 8'hE4, 8'hFF);
    als_data <= 16'hFFFF;
    als_done <= 1'b1;
    hit(16'h16E4);
    hit(16'($random(seed)) & 16'h0FFF);
    hit(16'h16E4);
    chk("int_n", 32'h1, link.int_n);
    hit(16'hFFFF);
    chk("int_n", 32'h0, link.int_n);
    dev(1'b1, pst_pkg::REG_FLAGS, 8'h00, 8'h01, 8'hFF);
    chk("irq", 32'h1, irq);
    dev(1'b0, pst_pkg::REG_FLAGS, 8'h00, 8'h00, 8'h00);
    chk("int_n", 32'h0, link.int_n);
    dev(1'b0, pst_pkg::REG_FLAGS, 8'h01, 8'h00, 8'h00);
    chk("int_n", 32'h1, link.int_n);
    chk("irq", 32'h0, irq);
    r = 8'($random(seed));
    dev(1'b0, pst_pkg::REG_UTH, 8'hFF, 8'h00, 8'h00);
    dev(1'b0, pst_pkg::REG_UTL, 8'hFF, 8'h00, 8'h00);
    dev(1'b0, pst_pkg::REG_LTH, 8'h16, 8'h00, 8'h00);
    dev(1'b0, pst_pkg::REG_LTL, r, 8'h00, 8'h00);
    dev(1'b1, pst_pkg::REG_LTL, 8'h00, r, 8'hFF);
    hit({8'h16, r});
    hit({8'h16, r} - 16'h1);
    hit(16'hFFFE);
    hit({8'h16, r} - 16'h1);
    chk("int_n", 32'h1, link.int_n);
    hit({8'h16, r} - 16'h1);
    chk("int_n", 32'h0, link.int_n);
    dev(1'b1, pst_pkg::REG_FLAGS, 8'h00, 8'h02, 8'hFF);
    dev(1'b0, pst_pkg::REG_FLAGS, 8'h02, 8'h00, 8'h00);
    chk("int_n", 32'h1, link.int_n);
    // ambient source, count of one, both ready flags on
    dev(1'b0, pst_pkg::REG_ICTL, 8'h0F, 8'h00, 8'h00);
    als_done <= 1'b1;
    hit(16'h0000);
    dev(1'b1, pst_pkg::REG_FLAGS, 8'h00, 8'h0D, 8'hFF);
    chk("irq", 32'h1, irq);
    close_out;
  end
endmodule : tb
`default_nettype wire
